// >>> rtl/rtpgc_top.sv
// Receive test pattern generator and checker with its configuration registers.
`timescale 1ns/10ps
`default_nettype none
`include "rtpgc_map.svh"
module rtpgc_top #(
  parameter logic [39:0] WIN_20_BITS = `RTPGC_WIN_20,
  parameter logic [39:0] WIN_30_BITS = `RTPGC_WIN_30,
  parameter logic [39:0] WIN_40_BITS = `RTPGC_WIN_40
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Generator output.
  output logic o_gen_data,
  output logic o_gen_active,
  // Received bit stream.
  input wire logic i_rx_data,
  input wire logic i_rx_valid,
  // Checker status.
  output logic o_chk_in_sync,
  output logic o_chk_sync_lost,
  output logic [15:0] o_chk_err_count,
  output logic o_chk_window_done,
  output logic [15:0] o_chk_window_errs
);

  rtpgc_pkg::rtpgc_byte_type pattern_select;
  rtpgc_pkg::rtpgc_byte_type checker_config;
  logic [63:0] user_pattern;
  logic [2:0] generator_mode_sel;
  logic [2:0] checker_mode_sel;
  logic generator_invert;
  logic checker_invert;
  logic sync_loss_mask;
  logic [1:0] check_interval_sel;
  logic [2:0] addr_upat;
  logic gen_p7_bit;
  logic gen_p31_bit;
  logic chk_p7_bit;
  logic chk_p31_bit;
  logic [5:0] gen_ptr;
  logic [5:0] chk_ptr;
  logic gen_on;
  logic chk_on;
  logic chk_bit;
  logic expected;
  logic bit_err;
  logic step;
  logic next_gen_bit;
  rtpgc_pkg::rtpgc_sync_state_type sync_state;
  logic sync_achieved;
  logic mask_hold;
  logic [6:0] good_cnt;
  logic [5:0] block_cnt;
  logic [3:0] block_errs;
  logic lose_now;
  logic [39:0] bit_cnt;
  logic [39:0] win_len;
  logic win_end;
  logic [15:0] err_sum;

  // Field views of the two control registers.
  assign generator_mode_sel = pattern_select[`RTPGC_GEN_MODE_HI:`RTPGC_GEN_MODE_LO];
  assign checker_mode_sel = pattern_select[`RTPGC_CHK_MODE_HI:`RTPGC_CHK_MODE_LO];
  assign generator_invert = pattern_select[`RTPGC_GEN_INV_BIT];
  assign checker_invert = pattern_select[`RTPGC_CHK_INV_BIT];
  assign sync_loss_mask = checker_config[`RTPGC_MASK_BIT];
  assign check_interval_sel = checker_config[`RTPGC_TB_HI:`RTPGC_TB_LO];
  assign addr_upat = 3'(i_reg_addr - `RTPGC_ADDR_UPAT_FIRST);

  // Codes above the user pattern fall outside every case below and so stay idle.
  assign gen_on = (generator_mode_sel == `RTPGC_MODE_PRBS7) ||
                  (generator_mode_sel == `RTPGC_MODE_PRBS31) ||
                  (generator_mode_sel == `RTPGC_MODE_USER);
  assign chk_on = (checker_mode_sel == `RTPGC_MODE_PRBS7) ||
                  (checker_mode_sel == `RTPGC_MODE_PRBS31) ||
                  (checker_mode_sel == `RTPGC_MODE_USER);

  // Selection register; reset leaves everything disabled and uninverted.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pattern_select <= `RTPGC_RST_SEL;
    end else if (i_reg_wr && i_reg_addr == `RTPGC_ADDR_SEL) begin
      pattern_select <= i_reg_wdata;
    end
  end

  // Checker configuration; only the low three bits are writable.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      checker_config <= `RTPGC_RST_CFG;
    end else if (i_reg_wr && i_reg_addr == `RTPGC_ADDR_CFG) begin
      checker_config <= i_reg_wdata & `RTPGC_CFG_RW_MASK;
    end
  end

  // User pattern bytes, least significant byte at the lowest address.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      user_pattern <= {8{`RTPGC_RST_UPAT}};
    end else if (i_reg_wr && i_reg_addr >= `RTPGC_ADDR_UPAT_FIRST &&
                 i_reg_addr <= `RTPGC_ADDR_UPAT_LAST) begin
      user_pattern[addr_upat*8 +: 8] <= i_reg_wdata;
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= `RTPGC_RST_RDATA;
    end else if (i_reg_rd) begin
      if (i_reg_addr == `RTPGC_ADDR_SEL) begin
        o_reg_rdata <= pattern_select;
      end else if (i_reg_addr == `RTPGC_ADDR_CFG) begin
        o_reg_rdata <= checker_config;
      end else if (i_reg_addr >= `RTPGC_ADDR_UPAT_FIRST &&
                   i_reg_addr <= `RTPGC_ADDR_UPAT_LAST) begin
        o_reg_rdata <= user_pattern[addr_upat*8 +: 8];
      end else begin
        o_reg_rdata <= `RTPGC_RST_RDATA;
      end
    end
  end

  // Separate generators per polynomial; each restarts from all ones while not selected.
  // A shared register would need the PRBS31 to PRBS7 pass through off to reseed.
  rtpgc_prbs #(.LEN(`RTPGC_P7_LEN), .TAP(`RTPGC_P7_TAP)) u_gen_p7 (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(generator_mode_sel != `RTPGC_MODE_PRBS7),
    .i_advance(1'b1),
    .i_self_sync(1'b0),
    .i_seed_bit(1'b0),
    .o_predict(gen_p7_bit)
  );

  rtpgc_prbs #(.LEN(`RTPGC_P31_LEN), .TAP(`RTPGC_P31_TAP)) u_gen_p31 (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(generator_mode_sel != `RTPGC_MODE_PRBS31),
    .i_advance(1'b1),
    .i_self_sync(1'b0),
    .i_seed_bit(1'b0),
    .o_predict(gen_p31_bit)
  );

  // Pick the generated bit; PRBS31 leaves inverted, then the optional invert applies.
  always_comb begin
    unique case (generator_mode_sel)
      `RTPGC_MODE_PRBS7: next_gen_bit = gen_p7_bit ^ generator_invert;
      `RTPGC_MODE_PRBS31: next_gen_bit = ~gen_p31_bit ^ generator_invert;
      `RTPGC_MODE_USER: next_gen_bit = user_pattern[gen_ptr] ^ generator_invert;
      default: next_gen_bit = 1'b0;
    endcase
  end

  // Generator output stage and user pattern pointer, sent least significant bit first.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gen_data <= 1'b0;
      o_gen_active <= 1'b0;
      gen_ptr <= '0;
    end else begin
      o_gen_data <= next_gen_bit;
      o_gen_active <= gen_on;
      gen_ptr <= (generator_mode_sel == `RTPGC_MODE_USER) ? gen_ptr + 6'h01 : '0;
    end
  end

  // Received data after the checker invert and, for PRBS31, after undoing its inversion.
  assign chk_bit = i_rx_data ^ checker_invert ^
                   (checker_mode_sel == `RTPGC_MODE_PRBS31);
  assign step = i_rx_valid && chk_on;

  // Predictors seed themselves from the line while hunting and fly free once locked.
  rtpgc_prbs #(.LEN(`RTPGC_P7_LEN), .TAP(`RTPGC_P7_TAP)) u_chk_p7 (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(checker_mode_sel != `RTPGC_MODE_PRBS7),
    .i_advance(step),
    .i_self_sync(sync_state == rtpgc_pkg::RTPGC_HUNT),
    .i_seed_bit(chk_bit),
    .o_predict(chk_p7_bit)
  );

  rtpgc_prbs #(.LEN(`RTPGC_P31_LEN), .TAP(`RTPGC_P31_TAP)) u_chk_p31 (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(checker_mode_sel != `RTPGC_MODE_PRBS31),
    .i_advance(step),
    .i_self_sync(sync_state == rtpgc_pkg::RTPGC_HUNT),
    .i_seed_bit(chk_bit),
    .o_predict(chk_p31_bit)
  );

  // Expected bit for the selected checker mode.
  always_comb begin
    unique case (checker_mode_sel)
      `RTPGC_MODE_PRBS7: expected = chk_p7_bit;
      `RTPGC_MODE_PRBS31: expected = chk_p31_bit;
      `RTPGC_MODE_USER: expected = user_pattern[chk_ptr];
      default: expected = chk_bit;
    endcase
  end

  assign bit_err = step && (chk_bit != expected);
  assign mask_hold = sync_loss_mask && sync_achieved;
  assign lose_now = bit_err && (block_errs + 4'h1 >= `RTPGC_LOSS_ERRS) && !mask_hold;

  // User pattern pointer; a miss while hunting holds it, slipping the phase one bit.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      chk_ptr <= '0;
    end else if (checker_mode_sel != `RTPGC_MODE_USER) begin
      chk_ptr <= '0;
    end else if (step && !(bit_err && sync_state == rtpgc_pkg::RTPGC_HUNT)) begin
      chk_ptr <= chk_ptr + 6'h01;
    end
  end

  // Sync machine: a run of good bits locks; too many errors in a block unlocks.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_state <= rtpgc_pkg::RTPGC_HUNT;
      sync_achieved <= 1'b0;
      good_cnt <= '0;
      block_cnt <= '0;
      block_errs <= '0;
      o_chk_sync_lost <= 1'b0;
    end else begin
      o_chk_sync_lost <= 1'b0;
      if (!chk_on) begin
        sync_state <= rtpgc_pkg::RTPGC_HUNT;
        sync_achieved <= 1'b0;
        good_cnt <= '0;
        block_cnt <= '0;
        block_errs <= '0;
      end else if (step) begin
        unique case (sync_state)
          rtpgc_pkg::RTPGC_HUNT: begin
            good_cnt <= bit_err ? '0 : good_cnt + 7'h01;
            if (!bit_err && good_cnt == `RTPGC_SYNC_GOOD - 7'h01) begin
              sync_state <= rtpgc_pkg::RTPGC_LOCKED;
              sync_achieved <= 1'b1;
              block_cnt <= '0;
              block_errs <= '0;
            end
          end
          rtpgc_pkg::RTPGC_LOCKED: begin
            block_cnt <= block_cnt + 6'h01;
            if (lose_now) begin
              sync_state <= rtpgc_pkg::RTPGC_HUNT;
              o_chk_sync_lost <= 1'b1;
              sync_achieved <= 1'b0;
              good_cnt <= '0;
            end else if (block_cnt == `RTPGC_BLOCK_LAST) begin
              block_errs <= '0;
            end else if (bit_err && block_errs != `RTPGC_LOSS_ERRS) begin
              block_errs <= block_errs + 4'h1;
            end
          end
        endcase
      end
    end
  end

  assign o_chk_in_sync = (sync_state == rtpgc_pkg::RTPGC_LOCKED);

  // Window length from the timebase; code 00 never ends.
  always_comb begin
    unique case (check_interval_sel)
      `RTPGC_TB_CONT: win_len = '0;
      `RTPGC_TB_20: win_len = WIN_20_BITS;
      `RTPGC_TB_30: win_len = WIN_30_BITS;
      `RTPGC_TB_40: win_len = WIN_40_BITS;
    endcase
  end

  assign win_end = step && (check_interval_sel != `RTPGC_TB_CONT) &&
                   (bit_cnt == win_len - 40'h1);
  // Errors count only while locked and saturate rather than wrap.
  assign err_sum = (bit_err && o_chk_in_sync && o_chk_err_count != `RTPGC_ERR_MAX) ?
                   o_chk_err_count + 16'h1 : o_chk_err_count;

  // Bit and error counters; a config write or a disabled checker restarts the window.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt <= '0;
      o_chk_err_count <= '0;
      o_chk_window_done <= 1'b0;
      o_chk_window_errs <= '0;
    end else begin
      o_chk_window_done <= 1'b0;
      if (!chk_on || (i_reg_wr && i_reg_addr == `RTPGC_ADDR_CFG)) begin
        bit_cnt <= '0;
        o_chk_err_count <= '0;
      end else if (win_end) begin
        bit_cnt <= '0;
        o_chk_err_count <= '0;
        o_chk_window_done <= 1'b1;
        o_chk_window_errs <= err_sum;
      end else if (step) begin
        bit_cnt <= bit_cnt + 40'h1;
        o_chk_err_count <= err_sum;
      end
    end
  end

endmodule : rtpgc_top
`default_nettype wire

// >>> rtl/rtpgc_map.svh
// Register map, field positions, codes and timing figures of the receive test pattern block.
`ifndef RTPGC_MAP_SVH
`define RTPGC_MAP_SVH

// Register addresses.
`define RTPGC_ADDR_SEL 8'h1D
`define RTPGC_ADDR_CFG 8'h1E
`define RTPGC_ADDR_UPAT_FIRST 8'h1F
`define RTPGC_ADDR_UPAT_LAST 8'h26

// Reset values.
`define RTPGC_RST_SEL 8'h00
`define RTPGC_RST_CFG 8'h02
`define RTPGC_RST_UPAT 8'hAA
`define RTPGC_RST_RDATA 8'h00

// Field positions.
`define RTPGC_CHK_INV_BIT 7
`define RTPGC_CHK_MODE_HI 6
`define RTPGC_CHK_MODE_LO 4
`define RTPGC_GEN_INV_BIT 3
`define RTPGC_GEN_MODE_HI 2
`define RTPGC_GEN_MODE_LO 0
`define RTPGC_MASK_BIT 2
`define RTPGC_TB_HI 1
`define RTPGC_TB_LO 0
`define RTPGC_CFG_RW_MASK 8'h07

// Mode and timebase codes.
`define RTPGC_MODE_OFF 3'h0
`define RTPGC_MODE_PRBS7 3'h1
`define RTPGC_MODE_PRBS31 3'h2
`define RTPGC_MODE_USER 3'h3
`define RTPGC_TB_CONT 2'h0
`define RTPGC_TB_20 2'h1
`define RTPGC_TB_30 2'h2
`define RTPGC_TB_40 2'h3

// Window lengths in bits.
`define RTPGC_WIN_20 40'h00000FFC00
`define RTPGC_WIN_30 40'h003FFFFC00
`define RTPGC_WIN_40 40'hFFFFFFFC00

// Polynomial lengths and taps.
`define RTPGC_P7_LEN 7
`define RTPGC_P7_TAP 6
`define RTPGC_P31_LEN 31
`define RTPGC_P31_TAP 28

// Synchronisation figures.
`define RTPGC_SYNC_GOOD 7'h40
`define RTPGC_LOSS_ERRS 4'h8
`define RTPGC_BLOCK_LAST 6'h3F
`define RTPGC_ERR_MAX 16'hFFFF
`define RTPGC_UPAT_LAST 6'h3F

`endif

// >>> rtl/rtpgc_pkg.sv
// Types shared by the receive test pattern block.
package rtpgc_pkg;

  typedef enum logic {
    RTPGC_HUNT,
    RTPGC_LOCKED
  } rtpgc_sync_state_type;

  typedef logic [7:0] rtpgc_byte_type;

endpackage : rtpgc_pkg

// >>> rtl/rtpgc_prbs.sv
// Pseudo-random sequence register used both to generate and to predict a pattern.
`timescale 1ns/10ps
`default_nettype none
module rtpgc_prbs #(
  parameter int unsigned LEN = 7,
  parameter int unsigned TAP = 6
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Control.
  input wire logic i_clear,
  input wire logic i_advance,
  input wire logic i_self_sync,
  input wire logic i_seed_bit,
  // Next bit of the sequence.
  output logic o_predict
);

  logic [LEN-1:0] state;

  // The all-ones start avoids the all-zero lockup state.
  assign o_predict = state[LEN-1] ^ state[TAP-1];

  // Self-synchronising mode shifts in received bits; otherwise the register flies on its own.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '1;
    end else if (i_clear) begin
      state <= '1;
    end else if (i_advance) begin
      state <= {state[LEN-2:0], (i_self_sync ? i_seed_bit : o_predict)};
    end
  end

endmodule : rtpgc_prbs
`default_nettype wire

// >>> dv/rtpgc_top_assertions.sv
// Port-level checker for the receive test pattern block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module rtpgc_top_assertions #(
  parameter logic [39:0] WIN_20_BITS = 40'h0000000064,
  parameter logic [39:0] WIN_30_BITS = 40'h00000000C8,
  parameter logic [39:0] WIN_40_BITS = 40'h000000012C
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Stream and status.
  input wire logic o_gen_data,
  input wire logic o_gen_active,
  input wire logic i_rx_valid,
  input wire logic o_chk_in_sync,
  input wire logic o_chk_sync_lost,
  input wire logic o_chk_window_done
);
  logic [7:0] sel_sh;
  logic [2:0] cfg_sh;
  logic [7:0] since;
  logic [39:0] vcnt;
  logic [39:0] win;

  // Shadow copies of both control registers, so each check knows the mode in force.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_sh <= 8'h00;
      cfg_sh <= 3'h2;
    end else if (i_reg_wr && i_reg_addr == 8'h1D) begin
      sel_sh <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == 8'h1E) begin
      cfg_sh <= i_reg_wdata[2:0];
    end
  end

  // Cycles since the last write; it saturates so that long runs never wrap.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      since <= 8'h00;
    end else if (i_reg_wr) begin
      since <= 8'h00;
    end else if (since != 8'hFF) begin
      since <= since + 8'h01;
    end
  end

  // Valid bits since the window was restarted; an overcount only loosens the check.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vcnt <= 40'h0000000000;
    end else if ((i_reg_wr && i_reg_addr == 8'h1E) || o_chk_window_done) begin
      vcnt <= 40'h0000000000;
    end else if (i_rx_valid) begin
      vcnt <= vcnt + 40'h0000000001;
    end
  end

  // Window length selected by the shadowed timebase field.
  assign win = (cfg_sh[1:0] == 2'h1) ? WIN_20_BITS :
               (cfg_sh[1:0] == 2'h2) ? WIN_30_BITS : WIN_40_BITS;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  AST_GEN_ON: assert property (i_reg_wr && i_reg_addr == 8'h1D &&
    i_reg_wdata[2:0] inside {3'h1, 3'h2, 3'h3} |-> ##2 o_gen_active)
    else $error("generator not active after a valid mode write");
  AST_GEN_OFF: assert property (i_reg_wr && i_reg_addr == 8'h1D &&
    !(i_reg_wdata[2:0] inside {3'h1, 3'h2, 3'h3}) |-> ##2 (!o_gen_active && !o_gen_data))
    else $error("generator running with an off or unused code");
  AST_PRBS7: assert property (sel_sh[2:0] == 3'h1 && since >= 8'h09 |->
    (o_gen_data ^ sel_sh[3]) == ($past(o_gen_data, 7) ^ $past(o_gen_data, 6)))
    else $error("short sequence breaks its recurrence");
  AST_PRBS31: assert property (sel_sh[2:0] == 3'h2 && since >= 8'h21 |->
    (o_gen_data ^ sel_sh[3] ^ 1'b1) == ($past(o_gen_data, 31) ^ $past(o_gen_data, 28)))
    else $error("long sequence has wrong polarity or recurrence");
  AST_USER: assert property (sel_sh[2:0] == 3'h3 && since >= 8'h42 |->
    o_gen_data == $past(o_gen_data, 64))
    else $error("user pattern does not repeat every 64 bits");
  AST_CHK_OFF: assert property (!(sel_sh[6:4] inside {3'h1, 3'h2, 3'h3}) &&
    since >= 8'h02 |-> !o_chk_in_sync && !o_chk_sync_lost)
    else $error("checker status while checker is off");
  AST_LOST: assert property (o_chk_sync_lost |->
    ##1 (!o_chk_sync_lost && !o_chk_in_sync))
    else $error("loss pulse longer than one cycle or lock kept");
  AST_MASK: assert property (o_chk_in_sync && cfg_sh[2] && !i_reg_wr &&
    since > 8'h02 |=> !o_chk_sync_lost)
    else $error("loss reported while the mask is set");
  AST_WIN: assert property (o_chk_window_done |-> cfg_sh[1:0] != 2'h0 &&
    vcnt + 40'h0000000002 >= win ##1 !o_chk_window_done)
    else $error("window ended early or in continuous mode");
  AST_RESET: assert property ($rose(i_reset_n) |->
    o_reg_rdata == 8'h00 && !o_gen_active && !o_chk_in_sync)
    else $error("outputs not cleared by reset");
  AST_SEL_RD: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h1D |=>
    o_reg_rdata == sel_sh)
    else $error("selection register read-back wrong");
  AST_CFG_RD: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h1E |=>
    o_reg_rdata == {5'h00, cfg_sh})
    else $error("checker configuration read-back wrong");
endmodule : rtpgc_top_assertions

bind rtpgc_top rtpgc_top_assertions #(
  .WIN_20_BITS(WIN_20_BITS), .WIN_30_BITS(WIN_30_BITS), .WIN_40_BITS(WIN_40_BITS)
) u_rtpgc_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .o_gen_data(o_gen_data), .o_gen_active(o_gen_active), .i_rx_valid(i_rx_valid),
  .o_chk_in_sync(o_chk_in_sync), .o_chk_sync_lost(o_chk_sync_lost),
  .o_chk_window_done(o_chk_window_done)
);
`default_nettype wire

// >>> dv/rtpgc_partner.sv
// Far-side model: the receive path that loops the generated stream back to the checker.
`timescale 1ns/10ps
`default_nettype none
module rtpgc_partner (
  // Clock.
  input wire logic i_clk,
  // Generated stream and bench controls.
  input wire logic i_gen_data,
  input wire logic i_flip,
  input wire logic i_valid,
  // Stream into the checker.
  output logic o_rx_data,
  output logic o_rx_valid
);
  // Retimed once like a real path; an idle line toggles so stale data is never seen.
  always_ff @(posedge i_clk) begin
    o_rx_valid <= i_valid;
    o_rx_data <= i_valid ? (i_gen_data ^ i_flip) : ~o_rx_data;
  end
endmodule : rtpgc_partner
`default_nettype wire

// >>> dv/rtpgc_top_tb_top.sv
// Self-checking bench for the receive test pattern block.
`timescale 1ns/10ps
`default_nettype none
module rtpgc_top_tb_top;
  typedef struct {logic [7:0] sel; logic act;} rtpgc_row_type;
  localparam logic [63:0] UPAT = 64'h0123456789ABCDEF;
  logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, flip = 1'b0, valid = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic gen_data, gen_act, rx_data, rx_valid, in_sync, lost, done, seen;
  logic [15:0] err_cnt, win_errs;
  logic [39:0] win [4] = '{40'h0, 40'h64, 40'hC8, 40'h12C};
  logic [7:0] gsel [6] = '{8'h02, 8'h0A, 8'h01, 8'h09, 8'h03, 8'h0B};
  rtpgc_row_type rows [8] = '{'{8'h00, 1'b0}, '{8'h11, 1'b1}, '{8'h22, 1'b1},
    '{8'h33, 1'b1}, '{8'h44, 1'b0}, '{8'h55, 1'b0}, '{8'h66, 1'b0}, '{8'h77, 1'b0}};
  int n_fail = 0;
  int comparisons = 0;
  int n;

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  rtpgc_top #(.WIN_20_BITS(40'h64), .WIN_30_BITS(40'hC8), .WIN_40_BITS(40'h12C)) i_dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_gen_data(gen_data),
    .o_gen_active(gen_act), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
    .o_chk_in_sync(in_sync), .o_chk_sync_lost(lost), .o_chk_err_count(err_cnt),
    .o_chk_window_done(done), .o_chk_window_errs(win_errs));
  rtpgc_partner i_far (.i_clk(clk), .i_gen_data(gen_data), .i_flip(flip),
    .i_valid(valid), .o_rx_data(rx_data), .o_rx_valid(rx_valid));

  // Comparison, counted and reported at once.
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // Register write: one strobe cycle, launched and released on falling edges.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask : rd_reg

  // Mode change always passes through off, which restarts the generator even when only the invert bit changes.
  task automatic mode(input logic [7:0] sel);
    wr_reg(8'h1D, 8'h00);
    wr_reg(8'h1D, sel);
  endtask : mode

  task automatic wait_sync(output logic got);
    got = 1'b0;
    for (int i = 0; i < 300 && got !== 1'b1; i++) begin
      @(negedge clk);
      got = in_sync;
    end
  endtask : wait_sync

  task automatic watch_lost(output logic got);
    got = 1'b0;
    repeat (40) begin
      @(negedge clk);
      got = got | lost;
    end
  endtask : watch_lost

  // Predicts the generator stream bit by bit from the selected mode.
  task automatic gen_chk(input logic [7:0] sel);
    logic [30:0] s;
    logic b;
    s = '1;
    mode(sel);
    for (int i = 0; i < 70; i++) begin
      @(negedge clk);
      if (sel[2:0] == 3'h1) begin
        b = s[6] ^ s[5];
      end else if (sel[2:0] == 3'h2) begin
        b = s[30] ^ s[27];
      end else begin
        b = UPAT[i % 64];
      end
      s = {s[29:0], b};
      chk(gen_data, b ^ sel[3] ^ (sel[2:0] == 3'h2));
    end
  endtask : gen_chk

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    rd_reg(8'h1D, 8'h00);
    rd_reg(8'h1E, 8'h02);
    foreach (rows[i]) begin
      wr_reg(8'h1D, rows[i].sel);
      repeat (2) @(negedge clk);
      chk(gen_act, rows[i].act);
      rd_reg(8'h1D, rows[i].sel);
    end
    for (int k = 0; k < 8; k++) begin
      wr_reg(8'h1F + 8'(k), UPAT[8 * k +: 8]);
    end
    foreach (gsel[i]) begin
      gen_chk(gsel[i]);
    end
    for (int m = 1; m < 4; m++) begin
      mode(8'(m * 17));
      wait_sync(seen);
      chk(seen, 1'b1);
    end
    mode(8'h99);
    wait_sync(seen);
    chk(seen, 1'b1);
    mode(8'h91);
    wait_sync(seen);
    chk(seen, 1'b0);
    // Loss of lock with the mask clear, then reacquisition, then the mask set.
    mode(8'h11);
    wait_sync(seen);
    wr_reg(8'h1E, 8'h00);
    flip = 1'b1;
    watch_lost(seen);
    chk(seen, 1'b1);
    flip = 1'b0;
    wait_sync(seen);
    chk(seen, 1'b1);
    wr_reg(8'h1E, 8'h04);
    flip = 1'b1;
    watch_lost(seen);
    chk(seen, 1'b0);
    chk(in_sync, 1'b1);
    // Locked and masked, all 39 inverted bits seen so far count as errors.
    chk(err_cnt, 16'h0027);
    flip = 1'b0;
    // Every timebase code, with the window length measured in cycles.
    for (int t = 0; t < 4; t++) begin
      wr_reg(8'h1E, 8'(t));
      for (n = 0; n < 400 && done !== 1'b1; n++) begin
        @(negedge clk);
      end
      chk(t == 0 ? n == 400 : n + 1 >= win[t] && n <= win[t] + 2, 1'b1);
      chk(win_errs, 16'h0000);
    end
    // Reset in mid-run, then reserved bits and an unmapped address.
    mode(8'h0B);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk(gen_act, 1'b0);
    rd_reg(8'h1D, 8'h00);
    rd_reg(8'h1E, 8'h02);
    wr_reg(8'h1E, 8'hFF);
    rd_reg(8'h1E, 8'h07);
    rd_reg(8'h50, 8'h00);
    conclude();
  end
endmodule : rtpgc_top_tb_top
`default_nettype wire
